//--- verilog/epd_pkg.sv
// constants and types shared by the encoder pulse divider output block
package epd_pkg;

    // ------------------------------------------------------------------
    // encoder resolutions
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        EPD_ENC_13 = 2'h0,
        EPD_ENC_17 = 2'h1,
        EPD_ENC_20 = 2'h2
    } epd_enc_t;

    localparam int EPD_ENC_W        = 20;
    localparam int EPD_CNT_W        = 19;
    localparam int EPD_SPD_W        = 16;

    // ------------------------------------------------------------------
    // pulse count setting bands
    // ------------------------------------------------------------------
    localparam logic [EPD_CNT_W-1:0] EPD_CNT_RESET   = 19'h00800;  // 2048
    localparam logic [EPD_CNT_W-1:0] EPD_CNT_MIN     = 19'h00010;  // 16
    localparam logic [EPD_CNT_W-1:0] EPD_CNT_MAX_13  = 19'h00800;  // 2048
    localparam logic [EPD_CNT_W-1:0] EPD_BAND1_MAX   = 19'h04000;  // 16384
    localparam logic [EPD_CNT_W-1:0] EPD_BAND2_MIN   = 19'h04002;  // 16386
    localparam logic [EPD_CNT_W-1:0] EPD_BAND2_MAX   = 19'h08000;  // 32768
    localparam logic [EPD_CNT_W-1:0] EPD_BAND3_MAX   = 19'h10000;  // 65536
    localparam logic [EPD_CNT_W-1:0] EPD_BAND4_MAX   = 19'h20000;  // 131072
    localparam logic [EPD_CNT_W-1:0] EPD_BAND5_MAX   = 19'h40000;  // 262144

    // ------------------------------------------------------------------
    // speed limits per band, min^-1
    // ------------------------------------------------------------------
    localparam logic [EPD_SPD_W-1:0] EPD_SPD_LIM1    = 16'h1770;   // 6000
    localparam logic [EPD_SPD_W-1:0] EPD_SPD_LIM2    = 16'h0bb8;   // 3000
    localparam logic [EPD_SPD_W-1:0] EPD_SPD_LIM3    = 16'h05dc;   // 1500
    localparam logic [EPD_SPD_W-1:0] EPD_SPD_LIM4    = 16'h02ee;   // 750
    localparam logic [EPD_SPD_W-1:0] EPD_SPD_LIM5    = 16'h0177;   // 375

    // ------------------------------------------------------------------
    // output rate limit
    // ------------------------------------------------------------------
    localparam int EPD_CLK_HZ       = 200_000_000;
    localparam int EPD_MAX_PPS      = 1_600_000;
    // least spacing between two output edges: 4 edges per pulse cycle
    localparam int EPD_EDGE_GAP     = (EPD_CLK_HZ + 4*EPD_MAX_PPS - 1) / (4*EPD_MAX_PPS);
    localparam int EPD_GAP_W        = 6;

endpackage : epd_pkg

//--- verilog/epd_step_if.sv
// step carrier between the scaler and the quadrature output stage
`timescale 1ns/10ps
`default_nettype none
interface epd_step_if;
    logic step;    // one scaled count step
    logic dir;     // 1: count up
    logic busy;    // output stage still pacing an edge

    modport src (output step, output dir, input busy);
    modport dst (input step, input dir, output busy);
endinterface : epd_step_if
`default_nettype wire

//--- verilog/epd_quad_out.sv
// quadrature a/b generator with edge pacing
`timescale 1ns/10ps
`default_nettype none
module epd_quad_out (
    // clock and reset
    input  wire logic      clock,
    input  wire logic      rst,
    // steps in
    epd_step_if.dst        stp,
    // pins out
    output logic           phase_a_q,
    output logic           phase_b_q
);

    logic [1:0]                        state_q, state_d;
    logic [epd_pkg::EPD_GAP_W-1:0]     gap_q, gap_d;

    // ------------------------------------------------------------------
    // gray state stepping, one output toggles per step
    // ------------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        gap_d   = (gap_q != '0) ? gap_q - 1'b1 : gap_q;
        if (stp.step && gap_q == '0) begin
            state_d = stp.dir ? state_q + 2'h1 : state_q - 2'h1;
            gap_d   = epd_pkg::EPD_GAP_W'(epd_pkg::EPD_EDGE_GAP - 1);
        end
    end

    assign stp.busy = (gap_q != '0);

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            state_q   <= 2'h0;
            gap_q     <= '0;
            phase_a_q <= 1'b0;
            phase_b_q <= 1'b0;
        end else begin
            state_q   <= state_d;
            gap_q     <= gap_d;
            // a leads b when counting up, 90 degrees apart
            phase_a_q <= state_d[1] ^ state_d[0];
            phase_b_q <= state_d[1];
        end
    end

endmodule : epd_quad_out
`default_nettype wire

//--- verilog/epd_top.sv
// encoder pulse divider output: scaled a/b/c pulses and alarms
`timescale 1ns/10ps
`default_nettype none
module epd_top #(
    parameter int ENC_W = epd_pkg::EPD_ENC_W
) (
    // clock and reset
    input  wire logic                          clock,
    input  wire logic                          rst,
    // setup: count and resolution taken at reset release, direction select unused
    input  wire logic [epd_pkg::EPD_CNT_W-1:0] output_pulse_count_setting,
    input  wire epd_pkg::epd_enc_t             enc_res,
    input  wire logic                          rotation_direction_select,
    // encoder increments, same clock domain
    input  wire logic                          enc_step,
    input  wire logic                          enc_up,
    input  wire logic                          enc_origin,
    input  wire logic [epd_pkg::EPD_SPD_W-1:0] motor_speed,
    // pulse outputs
    output logic                               quad_phase_a_out,
    output logic                               quad_phase_b_out,
    output logic                               origin_pulse_out,
    // alarms
    output logic                               pulse_setting_alarm,
    output logic                               pulse_overspeed_alarm
);

    typedef enum logic [1:0] {
        EPD_ST_LOAD = 2'b01,
        EPD_ST_RUN  = 2'b10
    } epd_state_t;

    epd_state_t                         st_q, st_d;
    logic [epd_pkg::EPD_CNT_W-1:0]      cnt_q, cnt_d;
    epd_pkg::epd_enc_t                  res_q, res_d;
    logic [epd_pkg::EPD_SPD_W-1:0]      lim_q, lim_d;
    logic [ENC_W:0]                     acc_q, acc_d;
    logic                               pend_q, pend_d;
    logic                               pdir_q, pdir_d;
    logic                               arm_q, arm_d;
    logic                               org_q, org_d;
    logic                               set_alm_q, set_alm_d;
    logic                               spd_alm_q, spd_alm_d;
    logic                               qa, qb, qa_q;
    logic [ENC_W:0]                     enc_res_cnt;
    logic [ENC_W:0]                     step_inc;

    epd_step_if stp ();

    // ------------------------------------------------------------------
    // helper functions
    // ------------------------------------------------------------------
    function automatic logic count_ok(input logic [epd_pkg::EPD_CNT_W-1:0] c,
                                      input epd_pkg::epd_enc_t r);
        logic ok;
        ok = 1'b0;
        if (c >= epd_pkg::EPD_CNT_MIN) begin
            unique case (r)
                epd_pkg::EPD_ENC_13: ok = (c <= epd_pkg::EPD_CNT_MAX_13);
                epd_pkg::EPD_ENC_17: ok = (c <= epd_pkg::EPD_BAND1_MAX)
                    || (c >= epd_pkg::EPD_BAND2_MIN && c <= epd_pkg::EPD_BAND2_MAX
                        && c[0] == 1'b0);
                default: begin
                    if (c <= epd_pkg::EPD_BAND1_MAX)      ok = 1'b1;
                    else if (c <= epd_pkg::EPD_BAND2_MAX) ok = (c >= epd_pkg::EPD_BAND2_MIN)
                                                               && c[0] == 1'b0;
                    else if (c <= epd_pkg::EPD_BAND3_MAX) ok = (c[1:0] == 2'h0);
                    else if (c <= epd_pkg::EPD_BAND4_MAX) ok = (c[2:0] == 3'h0);
                    else if (c <= epd_pkg::EPD_BAND5_MAX) ok = (c[3:0] == 4'h0);
                    else                                  ok = 1'b0;
                end
            endcase
        end
        return ok;
    endfunction : count_ok

    function automatic logic [epd_pkg::EPD_SPD_W-1:0] speed_limit(
            input logic [epd_pkg::EPD_CNT_W-1:0] c);
        if (c <= epd_pkg::EPD_BAND1_MAX)      return epd_pkg::EPD_SPD_LIM1;
        else if (c <= epd_pkg::EPD_BAND2_MAX) return epd_pkg::EPD_SPD_LIM2;
        else if (c <= epd_pkg::EPD_BAND3_MAX) return epd_pkg::EPD_SPD_LIM3;
        else if (c <= epd_pkg::EPD_BAND4_MAX) return epd_pkg::EPD_SPD_LIM4;
        else                                  return epd_pkg::EPD_SPD_LIM5;
    endfunction : speed_limit

    // encoder counts per revolution for the chosen resolution
    always_comb begin
        unique case (res_q)
            epd_pkg::EPD_ENC_13: enc_res_cnt = (ENC_W+1)'(1) << 13;
            epd_pkg::EPD_ENC_17: enc_res_cnt = (ENC_W+1)'(1) << 17;
            default:             enc_res_cnt = (ENC_W+1)'(1) << 20;
        endcase
    end

    // ------------------------------------------------------------------
    // setup capture, divider, origin and alarms
    // ------------------------------------------------------------------
    always_comb begin
        st_d      = st_q;
        cnt_d     = cnt_q;
        res_d     = res_q;
        lim_d     = lim_q;
        acc_d     = acc_q;
        pend_d    = pend_q;
        pdir_d    = pdir_q;
        arm_d     = arm_q;
        org_d     = org_q;
        set_alm_d = set_alm_q;
        spd_alm_d = spd_alm_q;
        unique case (st_q)
            EPD_ST_LOAD: begin
                // settings take effect only after a restart
                cnt_d     = output_pulse_count_setting;
                res_d     = enc_res;
                lim_d     = speed_limit(output_pulse_count_setting);
                set_alm_d = ~count_ok(output_pulse_count_setting, enc_res);
                st_d      = EPD_ST_RUN;
            end
            EPD_ST_RUN: begin
                // pending edge is taken by the pacer when it is idle; a new
                // overflow below re-queues one in the same cycle
                if (pend_q && !stp.busy) begin
                    pend_d = 1'b0;
                end
                // the direction select is not used anywhere in this block and never
                // changes the output phasing, so it is not folded in here
                if (enc_step && !set_alm_q) begin
                    // rate scaling: accumulate count per encoder step
                    if (enc_up) begin
                        if (acc_q + step_inc >= enc_res_cnt) begin
                            acc_d  = acc_q + step_inc - enc_res_cnt;
                            pend_d = 1'b1;
                            pdir_d = 1'b1;
                        end else begin
                            acc_d = acc_q + step_inc;
                        end
                    end else begin
                        if (acc_q < step_inc) begin
                            acc_d  = acc_q + enc_res_cnt - step_inc;
                            pend_d = 1'b1;
                            pdir_d = 1'b0;
                        end else begin
                            acc_d = acc_q - step_inc;
                        end
                    end
                end
                // origin: arm on encoder index, fire on next phase a rise
                if (enc_origin) begin
                    arm_d = 1'b1;
                end
                if (org_q && qa_q && !qa) begin
                    org_d = 1'b0;
                end else if (arm_q && qa && !qa_q) begin
                    org_d = 1'b1;
                    arm_d = enc_origin;
                end
                spd_alm_d = spd_alm_q | (motor_speed > lim_q);
            end
            default: st_d = EPD_ST_LOAD;
        endcase
    end

    // four output edges per programmed pulse cycle
    assign step_inc = (ENC_W+1)'(cnt_q) << 2;
    assign stp.step = pend_q;
    assign stp.dir  = pdir_q;

    // ------------------------------------------------------------------
    // quadrature stage
    // ------------------------------------------------------------------
    epd_quad_out u_quad (
        .clock     (clock),
        .rst       (rst),
        .stp       (stp),
        .phase_a_q (qa),
        .phase_b_q (qb)
    );

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            st_q                  <= EPD_ST_LOAD;
            cnt_q                 <= epd_pkg::EPD_CNT_RESET;
            res_q                 <= epd_pkg::EPD_ENC_20;
            lim_q                 <= epd_pkg::EPD_SPD_LIM1;
            acc_q                 <= '0;
            pend_q                <= 1'b0;
            pdir_q                <= 1'b1;
            arm_q                 <= 1'b0;
            org_q                 <= 1'b0;
            set_alm_q             <= 1'b0;
            spd_alm_q             <= 1'b0;
            qa_q                  <= 1'b0;
            quad_phase_a_out      <= 1'b0;
            quad_phase_b_out      <= 1'b0;
            origin_pulse_out      <= 1'b0;
            pulse_setting_alarm   <= 1'b0;
            pulse_overspeed_alarm <= 1'b0;
        end else begin
            st_q                  <= st_d;
            cnt_q                 <= cnt_d;
            res_q                 <= res_d;
            lim_q                 <= lim_d;
            acc_q                 <= acc_d;
            pend_q                <= pend_d;
            pdir_q                <= pdir_d;
            arm_q                 <= arm_d;
            org_q                 <= org_d;
            set_alm_q             <= set_alm_d;
            spd_alm_q             <= spd_alm_d;
            qa_q                  <= qa;
            quad_phase_a_out      <= qa;
            quad_phase_b_out      <= qb;
            origin_pulse_out      <= org_d;
            pulse_setting_alarm   <= set_alm_d;
            pulse_overspeed_alarm <= spd_alm_d;
        end
    end

endmodule : epd_top
`default_nettype wire

//--- verif/epd_host_rx.sv
// host side model that decodes the quadrature and origin pins
`timescale 1ns/10ps
`default_nettype none
module epd_host_rx (
    // clock and reset
    input  wire logic          clock,
    input  wire logic          rst,
    // pulse pins from the block
    input  wire logic          ph_a,
    input  wire logic          ph_b,
    input  wire logic          ph_c,
    // decoded results
    output logic signed [31:0] pos_q,
    output logic [15:0]        n_org_q,
    output logic [15:0]        n_arise_q,
    output logic [15:0]        c_len_q,
    output logic [15:0]        a_len_q,
    output logic               bad_q,
    output logic               homed_q
);
    logic        a_q;
    logic        b_q;
    logic        c_q;
    logic [15:0] cw_q;
    logic [15:0] aw_q;

    // count edges, a leading b is forward motion
    always_ff @(posedge clock) begin
        if (rst) begin
            {a_q, b_q, c_q, bad_q, homed_q} <= 5'h0;
            {pos_q, n_org_q, n_arise_q} <= 64'h0;
            {c_len_q, a_len_q, cw_q, aw_q} <= 64'h0;
        end else begin
            a_q <= ph_a;
            b_q <= ph_b;
            c_q <= ph_c;
            if (ph_a != a_q && ph_b != b_q) bad_q <= 1'b1;
            else if (ph_a != a_q) pos_q <= (ph_a != ph_b) ? pos_q + 32'sh1 : pos_q - 32'sh1;
            else if (ph_b != b_q) pos_q <= (ph_b == ph_a) ? pos_q + 32'sh1 : pos_q - 32'sh1;
            if (ph_a && !a_q) n_arise_q <= n_arise_q + 16'h1;
            cw_q <= ph_c ? cw_q + 16'h1 : 16'h0;
            aw_q <= ph_a ? aw_q + 16'h1 : 16'h0;
            if (!ph_c && c_q) c_len_q <= cw_q;
            if (!ph_a && a_q) a_len_q <= aw_q;
            if (ph_c && !c_q) n_org_q <= n_org_q + 16'h1;
            // origin trusted only once a full turn has passed
            if (ph_c && !c_q && n_org_q != 16'h0) homed_q <= 1'b1;
        end
    end
endmodule : epd_host_rx
`default_nettype wire

//--- verif/epd_top_asserts.sv
// port assertions for the encoder pulse divider output
`timescale 1ns/10ps
`default_nettype none
module epd_top_asserts #(
    parameter int ENC_W = epd_pkg::EPD_ENC_W
) (
    // clock and reset
    input  wire logic                          clock,
    input  wire logic                          rst,
    // setup and speed
    input  wire logic [epd_pkg::EPD_CNT_W-1:0] output_pulse_count_setting,
    input  wire logic [epd_pkg::EPD_SPD_W-1:0] motor_speed,
    // outputs watched
    input  wire logic                          quad_phase_a_out,
    input  wire logic                          quad_phase_b_out,
    input  wire logic                          origin_pulse_out,
    input  wire logic                          pulse_setting_alarm,
    input  wire logic                          pulse_overspeed_alarm
);
    logic        a_q, b_q, seen_q, seen_d, edge_w;
    logic [5:0]  gap_q, gap_d;
    logic [15:0] lim_w;

    // edge spacing counter and band speed limit
    always_comb begin
        edge_w = (quad_phase_a_out != a_q) || (quad_phase_b_out != b_q);
        gap_d = edge_w ? 6'h1 : ((gap_q == 6'h3f) ? gap_q : gap_q + 6'h1);
        seen_d = seen_q || edge_w;
        if (output_pulse_count_setting <= epd_pkg::EPD_BAND1_MAX) lim_w = epd_pkg::EPD_SPD_LIM1;
        else if (output_pulse_count_setting <= epd_pkg::EPD_BAND2_MAX) lim_w = epd_pkg::EPD_SPD_LIM2;
        else if (output_pulse_count_setting <= epd_pkg::EPD_BAND3_MAX) lim_w = epd_pkg::EPD_SPD_LIM3;
        else if (output_pulse_count_setting <= epd_pkg::EPD_BAND4_MAX) lim_w = epd_pkg::EPD_SPD_LIM4;
        else lim_w = epd_pkg::EPD_SPD_LIM5;
    end

    // register helper state
    always_ff @(posedge clock) begin
        if (rst) begin
            {a_q, b_q, seen_q, gap_q} <= 9'h0;
        end else begin
            {a_q, b_q, seen_q, gap_q} <= {quad_phase_a_out, quad_phase_b_out, seen_d, gap_d};
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    a_one_edge: assert property (!($changed(quad_phase_a_out) && $changed(quad_phase_b_out)))
        else $error("a and b moved together");
    a_edge_gap: assert property (edge_w && seen_q |-> gap_q >= epd_pkg::EPD_EDGE_GAP)
        else $error("output edges too close");
    a_origin_in_a: assert property ($rose(origin_pulse_out) |-> quad_phase_a_out)
        else $error("origin rose outside a high");
    a_origin_ends: assert property ($fell(quad_phase_a_out) |-> ##[0:1] !origin_pulse_out)
        else $error("origin outlived a high");
    a_reset_quiet: assert property ($fell(rst) |-> !(quad_phase_a_out || quad_phase_b_out
        || origin_pulse_out || pulse_setting_alarm || pulse_overspeed_alarm))
        else $error("outputs not quiet at reset release");
    a_set_sticky: assert property (pulse_setting_alarm |=> pulse_setting_alarm)
        else $error("setting alarm dropped");
    a_setting_mutes: assert property (pulse_setting_alarm |=> $stable({quad_phase_a_out, quad_phase_b_out}))
        else $error("pulses moved under setting alarm");
    a_ovs_sticky: assert property (pulse_overspeed_alarm |=> pulse_overspeed_alarm)
        else $error("overspeed alarm dropped");
    a_ovs_cause: assert property ($rose(pulse_overspeed_alarm) |-> $past(motor_speed) > lim_w)
        else $error("overspeed alarm without overspeed");
endmodule : epd_top_asserts

bind epd_top epd_top_asserts #(.ENC_W(ENC_W)) u_asserts (
    .clock(clock), .rst(rst), .output_pulse_count_setting(output_pulse_count_setting),
    .motor_speed(motor_speed), .quad_phase_a_out(quad_phase_a_out),
    .quad_phase_b_out(quad_phase_b_out), .origin_pulse_out(origin_pulse_out),
    .pulse_setting_alarm(pulse_setting_alarm), .pulse_overspeed_alarm(pulse_overspeed_alarm)
);
`default_nettype wire

//--- verif/encoder_pulse_divider_output_bench.sv
// self-checking bench for the encoder pulse divider output
`timescale 1ns/10ps
`default_nettype none
module encoder_pulse_divider_output_bench;
    typedef struct packed {
        logic [18:0] set;
        logic [1:0]  res;
        logic [15:0] spd;
        logic        sa;
        logic        oa;
    } epd_row_t;
    localparam epd_row_t ROWS [0:18] = '{
        '{19'h00800, 2'h0, 16'h1770, 1'b0, 1'b0}, '{19'h00800, 2'h0, 16'h1771, 1'b0, 1'b1},
        '{19'h00801, 2'h0, 16'h0000, 1'b1, 1'b0}, '{19'h0000f, 2'h1, 16'h0000, 1'b1, 1'b0},
        '{19'h00010, 2'h1, 16'h0000, 1'b0, 1'b0}, '{19'h04001, 2'h1, 16'h0000, 1'b1, 1'b0},
        '{19'h04003, 2'h1, 16'h0000, 1'b1, 1'b0}, '{19'h04002, 2'h1, 16'h0bb9, 1'b0, 1'b1},
        '{19'h08000, 2'h1, 16'h0bb8, 1'b0, 1'b0}, '{19'h08004, 2'h1, 16'h0000, 1'b1, 1'b0},
        '{19'h08004, 2'h2, 16'h05dc, 1'b0, 1'b0}, '{19'h061a8, 2'h2, 16'h0000, 1'b0, 1'b0},
        '{19'h061a9, 2'h2, 16'h0000, 1'b1, 1'b0}, '{19'h10004, 2'h2, 16'h0000, 1'b1, 1'b0},
        '{19'h10008, 2'h2, 16'h02ef, 1'b0, 1'b1}, '{19'h20008, 2'h2, 16'h0000, 1'b1, 1'b0},
        '{19'h20010, 2'h2, 16'h0177, 1'b0, 1'b0}, '{19'h40000, 2'h2, 16'h0178, 1'b0, 1'b1},
        '{19'h40010, 2'h2, 16'h0000, 1'b1, 1'b0}};

    logic              clock = 1'b0;
    logic              rst = 1'b1;
    logic [18:0]       setting = 19'h00800;
    epd_pkg::epd_enc_t enc_res = epd_pkg::EPD_ENC_13;
    logic              dir_sel = 1'b0;
    logic              enc_step = 1'b0;
    logic              enc_up = 1'b0;
    logic              enc_origin = 1'b0;
    logic [15:0]       speed = 16'h0;
    logic              qa, qb, qc, set_al, ovs_al, bad, homed;
    logic signed [31:0] pos;
    logic [15:0]       n_org, n_arise, c_len, a_len;
    int                n_mismatch = 0;
    int                n_tests = 0;

    // 200 mhz clock
    always #2.5 clock = ~clock;

    epd_top u_epd_top (.clock(clock), .rst(rst), .output_pulse_count_setting(setting),
        .enc_res(enc_res), .rotation_direction_select(dir_sel), .enc_step(enc_step),
        .enc_up(enc_up), .enc_origin(enc_origin), .motor_speed(speed),
        .quad_phase_a_out(qa), .quad_phase_b_out(qb), .origin_pulse_out(qc),
        .pulse_setting_alarm(set_al), .pulse_overspeed_alarm(ovs_al));
    epd_host_rx u_epd_host_rx (.clock(clock), .rst(rst), .ph_a(qa), .ph_b(qb), .ph_c(qc),
        .pos_q(pos), .n_org_q(n_org), .n_arise_q(n_arise), .c_len_q(c_len), .a_len_q(a_len),
        .bad_q(bad), .homed_q(homed));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: saw %0h expected %0h", $time, seen, exp);
        end
    endtask : chk

    task automatic restart(input logic [18:0] s, input logic [1:0] r, input logic d,
                           input logic [15:0] sp);
        @(negedge clock);
        rst = 1'b1;
        setting = s;
        enc_res = epd_pkg::epd_enc_t'(r);
        dir_sel = d;
        speed = sp;
        repeat (4) @(negedge clock);
        rst = 1'b0;
        repeat (4) @(negedge clock);
    endtask : restart

    // one step per cycle, encoder index on the first step
    task automatic turn(input logic up, input int n);
        for (int i = 0; i < n; i++) begin
            @(negedge clock);
            enc_step = 1'b1;
            enc_up = up;
            enc_origin = (i == 0);
        end
        @(negedge clock);
        enc_step = 1'b0;
        enc_origin = 1'b0;
        repeat (300) @(negedge clock);
    endtask : turn

    task automatic wrap_up;
        $display("Checks %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : wrap_up

    // main sequence: table of settings, then pulse traffic
    initial begin
        repeat (4) @(negedge clock);
        rst = 1'b0;
        @(negedge clock);
        chk({qa, qb, qc, set_al, ovs_al}, 32'h0);
        foreach (ROWS[i]) begin
            restart(ROWS[i].set, ROWS[i].res, 1'b0, ROWS[i].spd);
            chk(set_al, ROWS[i].sa);
            chk(ovs_al, ROWS[i].oa);
        end
        restart(19'h10, 2'h0, 1'b0, 16'h0);
        turn(1'b1, 8192);
        chk(pos, 32'h40);
        chk(n_arise, 32'h10);
        chk(n_org, 32'h1);
        chk(c_len, a_len);
        chk(bad, 32'h0);
        turn(1'b0, 8192);
        chk(pos, 32'h0);
        chk(n_org, 32'h2);
        chk(homed, 32'h1);
        restart(19'h10, 2'h0, 1'b1, 16'h0);
        turn(1'b1, 8192);
        chk(pos, 32'h40);
        restart(19'h801, 2'h0, 1'b0, 16'h0);
        turn(1'b1, 512);
        chk(pos, 32'h0);
        restart(19'h800, 2'h0, 1'b0, 16'h0);
        turn(1'b1, 1024);
        chk(pos > 0 && pos <= 32'sh2a, 32'h1);
        wrap_up;
    end

    // watchdog against a hang
    initial begin
        #400000;
        n_mismatch++;
        wrap_up;
    end
endmodule : encoder_pulse_divider_output_bench
`default_nettype wire
